// >>> spc_pkg.sv
// Purpose: shared constants and types for the six-line port with comparators
// Assumes: single 100 MHz clock, plain register port with one-cycle read latency
// Notes: register offsets are byte addresses on an 8-bit register port
package spc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] SPC_ADDR_DATA = 4'h0;   // port data register
    localparam logic [3:0] SPC_ADDR_MODE = 4'h1;   // port3_mode_reg
    localparam logic [3:0] SPC_ADDR_CFG = 4'h2;    // port_config_reg
    localparam logic [3:0] SPC_ADDR_EDGE = 4'h3;   // interrupt request register (edge select)
    localparam logic [3:0] SPC_ADDR_STAT = 4'h4;   // sticky event status, write one to clear
    localparam logic [3:0] SPC_ADDR_MASK = 4'h5;   // event mask

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SPC_MODE_ANALOG_BIT = 1;
    localparam int SPC_CFG_CMP_OUT_BIT = 0;
    localparam int SPC_CFG_LOW_EMI_BIT = 1;
    localparam int SPC_EDGE_LO_BIT = 6;
    localparam int SPC_EDGE_HI_BIT = 7;
    localparam int SPC_STAT_IRQ_A = 0;
    localparam int SPC_STAT_IRQ_B = 1;
    localparam int SPC_STAT_IRQ_C = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SPC_MODE_RST = 8'h00;
    localparam logic [7:0] SPC_CFG_RST = 8'h00;
    localparam logic [7:0] SPC_EDGE_RST = 8'h00;
    localparam logic [2:0] SPC_OUT_RST = 3'h0;
    localparam logic [2:0] SPC_MASK_RST = 3'h0;

    // edge selection codes held in bits 7:6 of the edge register
    typedef enum logic [1:0] {
        SPC_EDGE_FALL = 2'h0,
        SPC_EDGE_RISE = 2'h1,
        SPC_EDGE_BOTH = 2'h2,
        SPC_EDGE_BOTH2 = 2'h3
    } spc_edge_t;

    // software register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spc_reg_req_t;

    // the three input lines
    typedef struct packed {
        logic ref_in;
        logic b;
        logic a;
    } spc_lines_t;

endpackage : spc_pkg

// >>> spc_port.sv
// Purpose: six-line general-purpose port: three inputs, three push-pull outputs, comparators, interrupts
// Assumes: inputs synchronous-free pins are resynchronised here; comparators are external analog cells
// Notes: interrupt events are sticky, masked onto one level output
//
// Behaviour
// RULE1 - six lines: three fixed inputs a, b, ref; three fixed outputs a, b, c
// RULE2 - inputs are plain digital inputs with no level-holding latch
// RULE3 - outputs always driven push-pull, no tri-state or open-drain option
// RULE4 - one global software bit selects reduced-emission drive for all outputs
// RULE5 - mode register bit 1 selects analog mode for inputs a and b
// RULE6 - in analog mode comparator results replace digital values of a and b
// RULE7 - ref line interrupt raised only on falling edge
// RULE8 - a and b interrupts rising, falling or both, chosen by bits 6 and 7
// RULE9 - timer input comes from line a, timer output drives line c
// RULE10 - handshake pairs: a with c, b with b; peer drives input side
// RULE11 - line b feeds irq b, ref feeds irq c, a feeds irq a and timer
// RULE12 - config bit 0 routes comparator outputs onto output line a
// RULE13 - analog mode: ref bit and irq c come from stop recovery source
// RULE14 - digital mode: ref is readable input bit and irq c source
// RULE15 - inputs synchronised by two flops, edges from successive synced samples
// RULE16 - after reset analog, comparator routing, low emission off; outputs at reset data
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module spc_port (
    input wire logic clk,
    input wire logic arst_n,
    input wire spc_pkg::spc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire spc_pkg::spc_lines_t line_in,
    input wire logic cmp_a_result,
    input wire logic cmp_b_result,
    input wire logic stop_recovery_src,
    input wire logic timer_out_pin,
    input wire logic hs_c_ready,
    input wire logic hs_b_ready,
    input wire logic hs_c_enable,
    input wire logic hs_b_enable,
    output logic line_out_a,
    output logic line_out_b,
    output logic line_out_c,
    output logic line_out_low_emi,
    output logic timer_in_pin,
    output logic data_valid_strobe_c,
    output logic data_valid_strobe_b,
    output logic ext_irq_a,
    output logic ext_irq_b,
    output logic ext_irq_c,
    output logic irq
);
    import spc_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // two-flop release of the asynchronous reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end
    // the rest of the block resets from this copy, so release is clean on clk

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] cfg_reg;
    logic [7:0] edge_reg;
    logic [2:0] out_data;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [2:0] evt;
    logic analog_mode;
    spc_edge_t edge_sel;

    assign analog_mode = mode_reg[SPC_MODE_ANALOG_BIT]; // RULE5
    assign edge_sel = spc_edge_t'(edge_reg[SPC_EDGE_HI_BIT:SPC_EDGE_LO_BIT]); // RULE8

    // software writes to control and output data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= SPC_MODE_RST; // RULE16
            cfg_reg <= SPC_CFG_RST; // RULE16
            edge_reg <= SPC_EDGE_RST;
            out_data <= SPC_OUT_RST; // RULE16
            mask <= SPC_MASK_RST;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                SPC_ADDR_MODE: mode_reg <= reg_req.wdata;
                SPC_ADDR_CFG: cfg_reg <= reg_req.wdata;
                SPC_ADDR_EDGE: edge_reg <= reg_req.wdata;
                // output data lives in bits 6:4, where reads show it
                SPC_ADDR_DATA: out_data <= reg_req.wdata[6:4];
                SPC_ADDR_MASK: mask <= reg_req.wdata[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync_meta;
    logic [4:0] sync_q;
    logic [4:0] raw_in;

    // inputs sampled as they are, no holding latch
    assign raw_in = {stop_recovery_src, cmp_b_result, cmp_a_result, line_in.b, line_in.a}; // RULE2

    // two-stage synchroniser on every source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= 5'h00;
            sync_q <= 5'h00;
        end else begin
            sync_meta <= raw_in; // RULE15
            sync_q <= sync_meta; // RULE15
        end
    end

    logic ref_meta;
    logic ref_q;

    // reference line synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_meta <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            ref_meta <= line_in.ref_in; // RULE15
            ref_q <= ref_meta; // RULE15
        end
    end

    // ------------------------------------------------------------
    // effective line values
    // ------------------------------------------------------------
    logic val_a;
    logic val_b;
    logic val_ref;

    // comparators replace digital a and b in analog mode
    // hazard: a mode switch swaps the source at once and may raise a false edge
    assign val_a = analog_mode ? sync_q[2] : sync_q[0]; // RULE6
    assign val_b = analog_mode ? sync_q[3] : sync_q[1]; // RULE6
    // ref bit follows stop recovery source in analog mode
    assign val_ref = analog_mode ? sync_q[4] : ref_q; // RULE13 RULE14

    // ------------------------------------------------------------
    // line map
    // ------------------------------------------------------------
    logic [2:0] in_view;

    // the three fixed inputs as software sees them, ref on top
    assign in_view = {val_ref, val_b, val_a}; // RULE1

    logic prev_a;
    logic prev_b;
    logic prev_ref;

    // previous samples for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_ref <= 1'b0;
        end else begin
            prev_a <= val_a; // RULE15
            prev_b <= val_b;
            prev_ref <= val_ref;
        end
    end

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic fall_ref;
    logic hit_a;
    logic hit_b;

    // edges compare the current synced sample with the one before
    assign rise_a = val_a & ~prev_a;
    assign fall_a = ~val_a & prev_a;
    assign rise_b = val_b & ~prev_b;
    assign fall_b = ~val_b & prev_b;
    assign fall_ref = ~val_ref & prev_ref; // RULE7

    // selectable edge for a and b
    always_comb begin
        case (edge_sel)
            SPC_EDGE_FALL: begin
                hit_a = fall_a; // RULE8
                hit_b = fall_b;
            end
            SPC_EDGE_RISE: begin
                hit_a = rise_a; // RULE8
                hit_b = rise_b;
            end
            default: begin
                hit_a = rise_a | fall_a; // RULE8
                hit_b = rise_b | fall_b;
            end
        endcase
    end

    // interrupt source mapping
    assign evt[SPC_STAT_IRQ_A] = hit_a; // RULE11
    assign evt[SPC_STAT_IRQ_B] = hit_b; // RULE11
    assign evt[SPC_STAT_IRQ_C] = fall_ref; // RULE11 RULE7

    // one-cycle request pulses to the interrupt controller
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_a <= 1'b0;
            ext_irq_b <= 1'b0;
            ext_irq_c <= 1'b0;
        end else begin
            ext_irq_a <= hit_a; // RULE11
            ext_irq_b <= hit_b; // RULE11
            ext_irq_c <= fall_ref; // RULE13 RULE14
        end
    end

    // ------------------------------------------------------------
    // sticky status and interrupt
    // ------------------------------------------------------------
    logic [2:0] stat_clr;

    assign stat_clr = (reg_req.wr && reg_req.addr == SPC_ADDR_STAT) ? reg_req.wdata[2:0] : 3'h0;

    // set wins over a write-one clear in the same cycle
    // so an event that lands beside its own clear is never lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat <= 3'h0;
        end else begin
            stat <= (stat & ~stat_clr) | evt;
        end
    end

    // level request, high while any unmasked event is pending
    assign irq = |(stat & mask);

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic cmp_route;
    logic cmp_xor;

    assign cmp_route = cfg_reg[SPC_CFG_CMP_OUT_BIT]; // RULE12

    // one pin carries both comparator results, so they are combined here
    assign cmp_xor = sync_q[2] ^ sync_q[3]; // RULE12

    // push-pull outputs, always driven
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_out_a <= SPC_OUT_RST[0]; // RULE16
            line_out_b <= SPC_OUT_RST[1];
            line_out_c <= SPC_OUT_RST[2];
            line_out_low_emi <= 1'b0;
        end else begin
            line_out_a <= cmp_route ? cmp_xor : out_data[0]; // RULE12 RULE3
            line_out_b <= hs_b_enable ? hs_b_ready : out_data[1]; // RULE10 RULE3
            line_out_c <= hs_c_enable ? hs_c_ready : (timer_out_pin | out_data[2]); // RULE9 RULE10
            line_out_low_emi <= cfg_reg[SPC_CFG_LOW_EMI_BIT]; // RULE4
        end
    end

    // timer and handshake inputs
    assign timer_in_pin = val_a; // RULE9 RULE11
    assign data_valid_strobe_c = val_a; // RULE10
    assign data_valid_strobe_b = val_b; // RULE10

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                SPC_ADDR_DATA: reg_rdata <= {1'b0, out_data, in_view, 1'b0}; // RULE14 RULE1
                SPC_ADDR_MODE: reg_rdata <= mode_reg;
                SPC_ADDR_CFG: reg_rdata <= cfg_reg;
                SPC_ADDR_EDGE: reg_rdata <= edge_reg;
                SPC_ADDR_STAT: reg_rdata <= {5'h00, stat};
                SPC_ADDR_MASK: reg_rdata <= {5'h00, mask};
                // unmapped addresses read as zero
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : spc_port

// >>> spc_port_props.sv
// Purpose: assertion checker for the six-line port
// Assumes: sees only the top ports; mode, config and edge fields shadowed from writes
// Notes: an input change sampled at edge k is seen at k+2 and raises its event at k+3
`timescale 1ns/1ps
module spc_port_props
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire spc_pkg::spc_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire spc_pkg::spc_lines_t line_in,
    input wire logic cmp_a_result,
    input wire logic cmp_b_result,
    input wire logic stop_recovery_src,
    input wire logic line_out_a,
    input wire logic line_out_low_emi,
    input wire logic timer_in_pin,
    input wire logic data_valid_strobe_c,
    input wire logic data_valid_strobe_b,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic ext_irq_c
);
    logic analog;
    logic cmp_out;
    logic [1:0] edg;
    logic asrc;
    logic bsrc;
    logic csrc;

    // shadow copies of the mode, config and edge fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            analog <= 1'b0;
            cmp_out <= 1'b0;
            edg <= 2'h0;
        end else if (reg_req.wr) begin
            if (reg_req.addr == SPC_ADDR_MODE) analog <= reg_req.wdata[SPC_MODE_ANALOG_BIT];
            if (reg_req.addr == SPC_ADDR_CFG) cmp_out <= reg_req.wdata[SPC_CFG_CMP_OUT_BIT];
            if (reg_req.addr == SPC_ADDR_EDGE) edg <= reg_req.wdata[7:6];
        end
    end

    // effective event sources per mode
    assign asrc = analog ? cmp_a_result : line_in.a;
    assign bsrc = analog ? cmp_b_result : line_in.b;
    assign csrc = analog ? stop_recovery_src : line_in.ref_in;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence edge_a; ($rose(asrc) && edg != 2'h0) || ($fell(asrc) && edg != 2'h1); endsequence
    sequence edge_b; ($rose(bsrc) && edg != 2'h0) || ($fell(bsrc) && edg != 2'h1); endsequence

    out_data_a: assert property (
        reg_req.wr && reg_req.addr == SPC_ADDR_DATA && !cmp_out |=> ##1 line_out_a == $past(reg_req.wdata[4], 2))
        else $error("output a does not follow data write");
    low_emi_a: assert property (
        reg_req.wr && reg_req.addr == SPC_ADDR_CFG |=> ##1 line_out_low_emi == $past(reg_req.wdata[1], 2))
        else $error("low emission select does not follow config write");
    in_sync_a: assert property (timer_in_pin == $past(asrc, 2))
        else $error("timer input not two cycles behind its source");
    strobe_pair_a: assert property (
        data_valid_strobe_c == $past(asrc, 2) && data_valid_strobe_b == $past(bsrc, 2))
        else $error("handshake input side wrong");
    c_fall_fires_a: assert property ($fell(csrc) |-> ##3 ext_irq_c)
        else $error("falling ref edge gave no event");
    c_rise_quiet_a: assert property ($rose(csrc) |-> ##3 !ext_irq_c)
        else $error("rising ref edge gave an event");
    a_edge_sel_a: assert property (edge_a |-> ##3 ext_irq_a)
        else $error("line a edge missed");
    b_edge_sel_a: assert property (edge_b |-> ##3 ext_irq_b)
        else $error("line b edge missed");
    b_edge_block_a: assert property ($rose(bsrc) && edg == 2'h0 |-> ##3 !ext_irq_b)
        else $error("line b rise fired in fall mode");
    rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : spc_port_props

bind spc_port spc_port_props chk_u (.clk, .arst_n, .reg_req, .reg_rdata, .line_in, .cmp_a_result,
    .cmp_b_result, .stop_recovery_src, .line_out_a, .line_out_low_emi, .timer_in_pin,
    .data_valid_strobe_c, .data_valid_strobe_b, .ext_irq_a, .ext_irq_b, .ext_irq_c);

// >>> spc_pins.sv
// Purpose: pins and comparators outside the port
// Assumes: pin levels 0 to 255, logic threshold at mid scale
// Notes: comparator result high while its line is above the reference
`timescale 1ns/1ps
module spc_pins
    import spc_pkg::*;
(
    input wire logic [7:0] lvl_a,
    input wire logic [7:0] lvl_b,
    input wire logic [7:0] lvl_ref,
    output spc_pkg::spc_lines_t line_in,
    output logic cmp_a_result,
    output logic cmp_b_result
);
    // peer drives the input side of each line
    assign line_in = '{ref_in: lvl_ref[7], b: lvl_b[7], a: lvl_a[7]};
    // both comparators share the reference line
    assign cmp_a_result = lvl_a > lvl_ref;
    assign cmp_b_result = lvl_b > lvl_ref;
endmodule : spc_pins

// >>> test_spc_port.sv
// Purpose: self-checking bench for the six-line port
// Assumes: pin model drives levels; hand-shake controls randomised in one loop, otherwise held off
// Notes: expected status worked out from the edge modes written
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: %h %h", $time, (g), (e)); end end
module test_spc_port;
    import spc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    spc_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic [7:0] lvl_a = 8'h00;
    logic [7:0] lvl_b = 8'h00;
    logic [7:0] lvl_ref = 8'h00;
    logic [7:0] d = 8'h00;
    logic [7:0] mask = 8'h03;
    logic stop_recovery_src = 1'b0;
    logic timer_out_pin = 1'b0;
    logic hs_c_ready = 1'b0, hs_b_ready = 1'b0, hs_c_enable = 1'b0, hs_b_enable = 1'b0;
    spc_lines_t line_in;
    logic cmp_a_result, cmp_b_result, line_out_a, line_out_b, line_out_c, line_out_low_emi;
    logic timer_in_pin, data_valid_strobe_c, data_valid_strobe_b, ext_irq_a, ext_irq_b, ext_irq_c, irq;
    int fails = 0;
    int checks = 0;
    int seed = 32'h25da;

    always #5 clk = ~clk;

    spc_pins pins_u (.lvl_a, .lvl_b, .lvl_ref, .line_in, .cmp_a_result, .cmp_b_result);
    spc_port dut_u (.clk, .arst_n, .reg_req, .reg_rdata, .line_in, .cmp_a_result, .cmp_b_result,
        .stop_recovery_src, .timer_out_pin, .hs_c_ready, .hs_b_ready, .hs_c_enable,
        .hs_b_enable, .line_out_a, .line_out_b, .line_out_c, .line_out_low_emi, .timer_in_pin,
        .data_valid_strobe_c, .data_valid_strobe_b, .ext_irq_a, .ext_irq_b, .ext_irq_c, .irq);

    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd
    // set pin levels, then check and clear the sticky status
    task automatic step(input logic [7:0] a, b, r, input logic s, input logic [7:0] e);
        @(posedge clk);
        lvl_a <= a;
        lvl_b <= b;
        lvl_ref <= r;
        stop_recovery_src <= s;
        repeat (6) @(posedge clk);
        rd(SPC_ADDR_STAT, e);
        `CHK(irq, |(e & mask))
        wr(SPC_ADDR_STAT, 8'h07);
        rd(SPC_ADDR_STAT, 8'h00);
    endtask : step
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 7; i++) rd(4'(i == 6 ? 15 : i), 8'h00);
        `CHK({line_out_c, line_out_b, line_out_a, line_out_low_emi}, {SPC_OUT_RST, 1'b0})
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed)) & 8'h70;
            timer_out_pin <= i[0];
            wr(SPC_ADDR_DATA, d);
            @(posedge clk);
            #1;
            `CHK({line_out_c, line_out_b, line_out_a}, {d[6] | timer_out_pin, d[5:4]})
            rd(SPC_ADDR_DATA, d);
        end
        // handshake pairs take over outputs b and c when enabled
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {hs_c_enable, hs_b_enable, hs_c_ready, hs_b_ready} <= 4'($random(seed));
            repeat (2) @(posedge clk);
            #1;
            `CHK(line_out_b, (hs_b_enable ? hs_b_ready : d[5]))
            `CHK(line_out_c, (hs_c_enable ? hs_c_ready : (d[6] | timer_out_pin)))
        end
        hs_c_enable <= 1'b0;
        hs_b_enable <= 1'b0;
        wr(SPC_ADDR_CFG, 8'h02);
        @(posedge clk);
        #1;
        `CHK(line_out_low_emi, 1'b1)
        rd(SPC_ADDR_CFG, 8'h02);
        wr(SPC_ADDR_CFG, 8'h00);
        wr(SPC_ADDR_MASK, mask);
        for (int e = 0; e < 4; e++) begin
            wr(SPC_ADDR_EDGE, 8'(e << 6));
            step(8'hFF, 8'hFF, 8'h00, 1'b0, e != 0 ? 8'h03 : 8'h00);
            step(8'h00, 8'h00, 8'h00, 1'b0, e != 1 ? 8'h03 : 8'h00);
        end
        step(8'h00, 8'h00, 8'hFF, 1'b0, 8'h00);
        rd(SPC_ADDR_DATA, d | 8'h08);
        step(8'h00, 8'h00, 8'h00, 1'b0, 8'h04);
        wr(SPC_ADDR_MODE, 8'h02);
        step(8'h40, 8'h00, 8'h20, 1'b1, 8'h01);
        `CHK(timer_in_pin, 1'b1)
        wr(SPC_ADDR_CFG, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(line_out_a, 1'b1)
        step(8'h40, 8'h00, 8'h20, 1'b0, 8'h04);
        report_and_stop();
    end
endmodule : test_spc_port
